//--- hdl/slotcap_pkg.sv
// Overview of operation
// - all fields read zero unless slot implemented
// - bits 4:0 flag present slot features
// - bit 5 flags surprise removal capability
// - bit 6 flags hot-plug capable slot
// - bits 14:7 writable power limit value, reset zero
// - bits 16:15 power limit scale code
// - power limit message on write or link-up
// - bit 18 hardwired to zero
// - bit 17 flags electromechanical interlock present
package slotcap_pkg;
  localparam logic [11:0] SLOTCAP_ADDR      = 12'h054;
  localparam logic [11:0] SLOTCAP_CFG_ADDR  = 12'h100;
  localparam logic [11:0] SLOTCAP_STAT_ADDR = 12'h104;
  localparam int          PRES_LSB          = 0;
  localparam int          PRES_W            = 5;
  localparam int          SURPRISE_BIT      = 5;
  localparam int          CAPABLE_BIT       = 6;
  localparam int          PLV_LSB           = 7;
  localparam int          PLV_W             = 8;
  localparam int          PLS_LSB           = 15;
  localparam int          PLS_W             = 2;
  localparam int          INTERLOCK_BIT     = 17;
  localparam int          NOTIFY_BIT        = 18;
  localparam int          SLOTNUM_LSB       = 19;
  localparam int          SLOTNUM_W         = 13;
  localparam logic [31:0] LOCK_MASK         = 32'hFFFA007F;
  localparam logic [31:0] RW_MASK           = 32'h0001FF80;
  localparam logic [31:0] RESET_VAL         = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  typedef enum logic [1:0] {SLOTCAP_IDLE, SLOTCAP_RESP} slotcap_state_t;
endpackage : slotcap_pkg

//--- hdl/slotcap_msg_if.sv
`timescale 1ns/1ps
interface slotcap_msg_if;
  logic       trigger;
  logic [7:0] value;
  logic [1:0] scale;
  modport src (output trigger, output value, output scale);
  modport dst (input trigger, input value, input scale);
endinterface : slotcap_msg_if

//--- hdl/slotcap_msg.sv
`timescale 1ns/1ps
module slotcap_msg
  import slotcap_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  dl_up,
  input  wire logic  msg_ack,
  slotcap_msg_if.dst req,
  output logic       pend,
  output logic [7:0] val_out,
  output logic [1:0] scl_out
);
  logic       dl_reg, dl_next, pend_next;
  logic [7:0] v_next;
  logic [1:0] s_next;
  always_comb begin
    dl_next   = dl_up;
    pend_next = pend;
    v_next    = val_out;
    s_next    = scl_out;
    if (pend && msg_ack) begin
      pend_next = 1'b0;
    end
    if (req.trigger || (dl_up && !dl_reg)) begin
      pend_next = 1'b1;
      v_next    = req.value;
      s_next    = req.scale;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dl_reg  <= 1'b0;
      pend    <= 1'b0;
      val_out <= 8'h00;
      scl_out <= 2'h0;
    end else begin
      dl_reg  <= dl_next;
      pend    <= pend_next;
      val_out <= v_next;
      scl_out <= s_next;
    end
  end
  AST_LINKUP_MSG: assert property (@(posedge clk) disable iff (!reset_n)
    (dl_up && !dl_reg) |=> pend) else $error("no message after link up");
endmodule : slotcap_msg

//--- hdl/slotcap_top.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module slotcap_top
  import slotcap_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        SLOT_IMPL,
  input  wire logic        DL_UP,
  input  wire logic        MSG_ACK,
  output logic             MSG_PEND,
  output logic [7:0]       MSG_VALUE,
  output logic [1:0]       MSG_SCALE
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]    cap_reg;
  logic [31:0]    cap_next;
  logic           unlock_reg;
  logic           unlock_next;
  logic           aw_reg;
  logic           aw_next;
  logic           w_reg;
  logic           w_next;
  logic [11:0]    awa_reg;
  logic [11:0]    awa_next;
  logic [31:0]    wd_reg;
  logic [31:0]    wd_next;
  logic [3:0]     ws_reg;
  logic [3:0]     ws_next;
  logic           bv_reg;
  logic           bv_next;
  logic           rv_reg;
  logic           rv_next;
  logic [1:0]     br_reg;
  logic [1:0]     br_next;
  logic [1:0]     rr_reg;
  logic [1:0]     rr_next;
  logic [31:0]    rd_reg;
  logic [31:0]    rd_next;
  logic           trig_reg;
  logic           trig_next;
  logic           awrdy_reg;
  logic           awrdy_next;
  logic           wrdy_reg;
  logic           wrdy_next;
  logic           ardy_reg;
  logic           ardy_next;
  logic [31:0]    view;
  logic [31:0]    wmask;
  logic [31:0]    bmask;
  logic           do_wr;
  slotcap_msg_if  msg_bus ();
  assign view = SLOT_IMPL ? (cap_reg & ~(32'h1 << NOTIFY_BIT)) : RESET_VAL;
  assign do_wr = aw_reg && w_reg && !bv_reg;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{ws_reg[i]}};
    end
    wmask = bmask & (RW_MASK | (unlock_reg ? LOCK_MASK : 32'h00000000));
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    aw_next     = aw_reg;
    awa_next    = awa_reg;
    w_next      = w_reg;
    wd_next     = wd_reg;
    ws_next     = ws_reg;
    bv_next     = bv_reg;
    br_next     = br_reg;
    rv_next     = rv_reg;
    rr_next     = rr_reg;
    rd_next     = rd_reg;
    cap_next    = cap_reg;
    unlock_next = unlock_reg;
    trig_next   = 1'b0;
    if (AWVALID && !aw_reg) begin
      aw_next  = 1'b1;
      awa_next = AWADDR;
    end
    if (WVALID && !w_reg) begin
      w_next  = 1'b1;
      wd_next = WDATA;
      ws_next = WSTRB;
    end
    if (do_wr) begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = RESP_OKAY;
      if (awa_reg[11:2] == SLOTCAP_ADDR[11:2]) begin
        if (SLOT_IMPL) begin
          cap_next  = (cap_reg & ~wmask) | (wd_reg & wmask);
          trig_next = 1'b1;
        end
      end else if (awa_reg[11:2] == SLOTCAP_CFG_ADDR[11:2]) begin
        if (ws_reg[0]) begin
          unlock_next = wd_reg[0];
        end
      end else if (awa_reg[11:2] != SLOTCAP_STAT_ADDR[11:2]) begin
        br_next = RESP_SLVERR;
      end
    end
    if (bv_reg && BREADY) begin
      bv_next = 1'b0;
    end
    if (rv_reg && RREADY) begin
      rv_next = 1'b0;
    end
    if (ARVALID && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      case (ARADDR[11:2])
        SLOTCAP_ADDR[11:2]:      rd_next = view;
        SLOTCAP_CFG_ADDR[11:2]:  rd_next = {31'h0, unlock_reg};
        SLOTCAP_STAT_ADDR[11:2]: rd_next = {30'h0, SLOT_IMPL, MSG_PEND};
        default: begin
          rd_next = 32'h00000000;
          rr_next = RESP_SLVERR;
        end
      endcase
    end
    awrdy_next = !aw_next;
    wrdy_next  = !w_next;
    ardy_next  = !rv_next;
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_reg    <= RESET_VAL;
      unlock_reg <= 1'b0;
      trig_reg   <= 1'b0;
      aw_reg     <= 1'b0;
      awa_reg    <= 12'h000;
      w_reg      <= 1'b0;
      wd_reg     <= 32'h00000000;
      ws_reg     <= 4'h0;
      bv_reg     <= 1'b0;
      br_reg     <= 2'h0;
      rv_reg     <= 1'b0;
      rr_reg     <= 2'h0;
      rd_reg     <= 32'h00000000;
      awrdy_reg  <= 1'b1;
      wrdy_reg   <= 1'b1;
      ardy_reg   <= 1'b1;
    end else begin
      cap_reg    <= cap_next;
      unlock_reg <= unlock_next;
      trig_reg   <= trig_next;
      aw_reg     <= aw_next;
      awa_reg    <= awa_next;
      w_reg      <= w_next;
      wd_reg     <= wd_next;
      ws_reg     <= ws_next;
      bv_reg     <= bv_next;
      br_reg     <= br_next;
      rv_reg     <= rv_next;
      rr_reg     <= rr_next;
      rd_reg     <= rd_next;
      awrdy_reg  <= awrdy_next;
      wrdy_reg   <= wrdy_next;
      ardy_reg   <= ardy_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign AWREADY = awrdy_reg;
  assign WREADY  = wrdy_reg;
  assign ARREADY = ardy_reg;
  assign BVALID  = bv_reg;
  assign BRESP   = br_reg;
  assign RVALID  = rv_reg;
  assign RRESP   = rr_reg;
  assign RDATA   = rd_reg;
  assign msg_bus.trigger = trig_reg;
  assign msg_bus.value   = cap_reg[PLV_LSB +: PLV_W];
  assign msg_bus.scale   = cap_reg[PLS_LSB +: PLS_W];
  slotcap_msg u_msg (
    .clk     (CLK),
    .reset_n (RESET_N),
    .dl_up   (DL_UP),
    .msg_ack (MSG_ACK),
    .req     (msg_bus),
    .pend    (MSG_PEND),
    .val_out (MSG_VALUE),
    .scl_out (MSG_SCALE)
  );
  ////////////////////////////////////////////////////////////////////////////
  AST_ZERO_NOSLOT: assert property (@(posedge CLK) disable iff (!RESET_N)
    (rv_reg && $rose(rv_reg) && !$past(SLOT_IMPL) && $past(ARADDR[11:2]) == SLOTCAP_ADDR[11:2]) |-> rd_reg == 32'h0)
    else $error("slot fields not zero");
  AST_NOTIFY_ZERO: assert property (@(posedge CLK) disable iff (!RESET_N)
    !view[NOTIFY_BIT]) else $error("bit 18 set");
  AST_WRITE_MSG: assert property (@(posedge CLK) disable iff (!RESET_N)
    trig_reg |=> MSG_PEND && MSG_VALUE == $past(cap_reg[PLV_LSB +: PLV_W]))
    else $error("write sent no message");
  AST_LOCKED: assert property (@(posedge CLK) disable iff (!RESET_N)
    !unlock_reg |=> (cap_reg & LOCK_MASK) == $past(cap_reg & LOCK_MASK))
    else $error("locked field changed");
  AST_PLV_WRITE: assert property (@(posedge CLK) disable iff (!RESET_N)
    (do_wr && SLOT_IMPL && awa_reg[11:2] == SLOTCAP_ADDR[11:2] && ws_reg == 4'hF)
    |=> cap_reg[PLS_LSB +: PLS_W] == $past(wd_reg[PLS_LSB +: PLS_W])
    && cap_reg[PLV_LSB +: PLV_W] == $past(wd_reg[PLV_LSB +: PLV_W]))
    else $error("power limit not stored");
  AST_PRES_VIEW: assert property (@(posedge CLK) disable iff (!RESET_N)
    SLOT_IMPL |-> view[PRES_LSB +: PRES_W] == cap_reg[PRES_LSB +: PRES_W]
    && view[SURPRISE_BIT] == cap_reg[SURPRISE_BIT]) else $error("flags hidden");
  AST_CAP_VIEW: assert property (@(posedge CLK) disable iff (!RESET_N)
    SLOT_IMPL |-> view[CAPABLE_BIT] == cap_reg[CAPABLE_BIT]
    && view[INTERLOCK_BIT] == cap_reg[INTERLOCK_BIT]
    && view[SLOTNUM_LSB +: SLOTNUM_W] == cap_reg[SLOTNUM_LSB +: SLOTNUM_W])
    else $error("capable flags hidden");
  AST_BRESP: assert property (@(posedge CLK) disable iff (!RESET_N)
    do_wr |=> BVALID) else $error("no write response");
  sequence noslot_write_s;
    do_wr && !SLOT_IMPL && awa_reg[11:2] == SLOTCAP_ADDR[11:2];
  endsequence
  sequence cap_kept_s;
    cap_reg == $past(cap_reg) && !trig_reg;
  endsequence
  sequence unlocked_write_s;
    do_wr && SLOT_IMPL && unlock_reg && ws_reg == 4'hF && awa_reg[11:2] == SLOTCAP_ADDR[11:2];
  endsequence
  sequence lock_landed_s;
    (cap_reg & LOCK_MASK) == ($past(wd_reg) & LOCK_MASK);
  endsequence
  property noslot_write_p;
    @(posedge CLK) disable iff (!RESET_N) noslot_write_s |=> cap_kept_s;
  endproperty
  property unlocked_write_p;
    @(posedge CLK) disable iff (!RESET_N) unlocked_write_s |=> lock_landed_s;
  endproperty
  AST_NOSLOT_WRITE: assert property (noslot_write_p) else $error("write landed without slot");
  AST_UNLOCK_WRITE: assert property (unlocked_write_p) else $error("lockable field not stored");
endmodule : slotcap_top

//--- testbench/slotcap_partner.sv
`timescale 1ns/1ps
module slotcap_partner (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       pend,
  input  wire logic [7:0] val,
  input  wire logic [1:0] scl,
  input  wire logic       slow,
  output logic            ack,
  output int              cnt,
  output logic [9:0]      last
);
  int wait_reg;
  // consumes one power limit message per pending, promptly or after a stall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack      <= 1'b0;
      cnt      <= 0;
      last     <= 10'h000;
      wait_reg <= 0;
    end else begin
      ack <= 1'b0;
      if (pend && !ack) begin
        if (wait_reg >= (slow ? 3 : 0)) begin
          ack      <= 1'b1;
          last     <= {scl, val};
          cnt      <= cnt + 1;
          wait_reg <= 0;
        end else begin
          wait_reg <= wait_reg + 1;
        end
      end
    end
  end
endmodule : slotcap_partner

//--- testbench/slot_capability_register_bench.sv
`timescale 1ns/1ps
module slot_capability_register_bench;
  import slotcap_pkg::*;
  logic        CLK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLOT_IMPL, DL_UP, slow, unl;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, MSG_ACK, MSG_PEND;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd, m, d, bm;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rs, MSG_SCALE;
  logic [7:0]  MSG_VALUE;
  logic [9:0]  last;
  int          cnt, n0, num_errors, num_checks, cyc, seed, i;
  slotcap_top slotcap_top_inst (.CLK(CLK), .RESET_N(RESET_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SLOT_IMPL(SLOT_IMPL),
    .DL_UP(DL_UP), .MSG_ACK(MSG_ACK), .MSG_PEND(MSG_PEND), .MSG_VALUE(MSG_VALUE), .MSG_SCALE(MSG_SCALE));
  slotcap_partner slotcap_partner_inst (.clk(CLK), .reset_n(RESET_N), .pend(MSG_PEND), .val(MSG_VALUE),
    .scl(MSG_SCALE), .slow(slow), .ack(MSG_ACK), .cnt(cnt), .last(last));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] s);
    @(posedge CLK);
    {AWADDR, WDATA, WSTRB, AWVALID, WVALID, BREADY} <= {a, dt, s, 3'b111};
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    chk("bresp", RESP_OKAY, BRESP);
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & (RW_MASK | (unl ? LOCK_MASK : 32'h0));
    if (a == SLOTCAP_ADDR && SLOT_IMPL) m = (m & ~bm) | (dt & bm);
    if (a == SLOTCAP_ADDR && SLOT_IMPL) n0++;
    if (a == SLOTCAP_CFG_ADDR && s[0]) unl = dt[0];
  endtask : wr
  task automatic rdx(input logic [11:0] a);
    @(posedge CLK);
    {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    {rd, rs} = {RDATA, RRESP};
    RREADY <= 1'b0;
  endtask : rdx
  task automatic rchk;
    rdx(SLOTCAP_ADDR);
    chk("slot_capabilities", SLOT_IMPL ? m : 32'h0, rd);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask : rchk
  task automatic mchk;
    for (int k = 0; k < 30 && cnt != n0; k++) @(posedge CLK);
    chk("msg count", n0, cnt);
    chk("msg payload", {22'h0, m[16:15], m[14:7]}, {22'h0, last});
  endtask : mchk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    {RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLOT_IMPL, DL_UP, slow, unl} = 10'h000;
    {AWADDR, ARADDR, WDATA, WSTRB, m} = 92'h0;
    n0   = 0;
    seed = 32'h4D20;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    SLOT_IMPL <= 1'b1;
    rchk;
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      d[16:15] = i[1:0];
      wr(SLOTCAP_ADDR, d, 4'hF);
      rchk;
      mchk;
    end
    $display("test locked writes done");
    slow <= 1'b1;
    wr(SLOTCAP_CFG_ADDR, 32'h1, 4'hF);
    rdx(SLOTCAP_CFG_ADDR);
    chk("unlock", {31'h0, unl}, rd);
    wr(SLOTCAP_ADDR, $random(seed), 4'hF);
    rchk;
    wr(SLOTCAP_ADDR, 32'hFFFFFFFF, 4'hF);
    rchk;
    wr(SLOTCAP_ADDR, 32'h0007FFFF, 4'hC);
    rchk;
    mchk;
    wr(SLOTCAP_CFG_ADDR, 32'h0, 4'hF);
    $display("test unlocked writes done");
    SLOT_IMPL <= 1'b0;
    wr(SLOTCAP_ADDR, 32'hFFFFFFFF, 4'hF);
    rchk;
    rdx(SLOTCAP_STAT_ADDR);
    chk("status", {30'h0, SLOT_IMPL, 1'b0}, rd);
    SLOT_IMPL <= 1'b1;
    rchk;
    rdx(SLOTCAP_STAT_ADDR);
    chk("status", {30'h0, SLOT_IMPL, 1'b0}, rd);
    mchk;
    $display("test no slot done");
    DL_UP <= 1'b1;
    n0++;
    mchk;
    repeat (10) @(posedge CLK);
    chk("msg count", n0, cnt);
    DL_UP <= 1'b0;
    repeat (2) @(posedge CLK);
    DL_UP <= 1'b1;
    n0++;
    mchk;
    $display("test link up done");
    rdx(12'h200);
    chk("unmapped resp", RESP_SLVERR, rs);
    chk("unmapped data", 32'h0, rd);
    $display("test unmapped done");
    close_out;
  end
endmodule : slot_capability_register_bench
